/* include/ihf_pkg.sv */
// constants, state encodings and register map of the host packet framer
package ihf_pkg;
  // packet bytes
  localparam logic [7:0] HDR_CMD = 8'h24;
  localparam logic [7:0] HDR_RSP = 8'h23;
  localparam logic [7:0] FTR_CR = 8'h0d;
  localparam logic [7:0] FTR_LF = 8'h0a;
  localparam logic [7:0] LEN_MIN = 8'h08;
  localparam logic [7:0] LEN_ACK = 8'h0a;
  localparam logic [7:0] LEN_RSP_BASE = 8'h0a;
  localparam logic [7:0] LEN_DATA_BASE = 8'h12;
  localparam logic [7:0] FRAME_BYTES = 8'h14;
  localparam logic [4:0] FRAME_LAST = 5'h13;
  localparam logic [7:0] TYPE_DATA = 8'hab;
  // command types of the no-reply commands
  localparam logic [7:0] TYPE_START = 8'h27;
  localparam logic [7:0] TYPE_STOP = 8'h28;
  localparam logic [7:0] TYPE_UTC = 8'h2d;
  // result codes
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_NAK = 8'h01;
  localparam logic [7:0] RC_WR_ERR = 8'h02;
  localparam logic [7:0] RC_RD_ERR = 8'h03;
  localparam logic [7:0] RC_BAD_ARG = 8'h04;
  localparam logic [7:0] RC_FL_WR = 8'h06;
  localparam logic [7:0] RC_FL_RD = 8'h07;
  localparam logic [7:0] RC_REG_WR = 8'h0a;
  localparam logic [7:0] RC_REG_RD = 8'h0b;
  localparam logic [7:0] RC_WEAR = 8'h0c;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_REPLY = 8'h1c;
  localparam logic [7:0] OFF_RESP = 8'h20;
  localparam logic [7:0] OFF_SSTAT = 8'h30;
  localparam logic [7:0] OFF_GO = 8'h34;
  localparam logic [7:0] OFF_TS_LO = 8'h38;
  localparam logic [7:0] OFF_TS_HI = 8'h3c;
  localparam logic [7:0] OFF_DATA = 8'h40;
  localparam logic [5:0] CMD_WORDS = 6'h05;
  localparam logic [5:0] RESP_WORDS = 6'h04;
  localparam logic [5:0] DATA_WORDS = 6'h0d;
  // field positions and reset values
  localparam int REPLY_KIND_BIT = 8;
  localparam int REPLY_LEN_LSB = 16;
  localparam int STATUS_SAMPLE_LSB = 8;
  localparam int STATUS_PKTNO_LSB = 16;
  localparam logic [4:0] RESP_MAX = 5'h10;
  localparam logic [7:0] FSEL_RST = 8'h1f;
  localparam logic [7:0] OFMT_RST = 8'h00;
  localparam logic [7:0] SSTAT_RST = 8'h00;
  localparam logic [5:0] DATA_BODY_END = 6'h3e;
  localparam logic [5:0] DATA_FIRST = 6'h0a;
  // timestamp tick
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS = 1000;
  localparam logic [3:0] US_TICKS = 4'(US_NS / CLK_PERIOD_NS);
  // packet kinds
  localparam logic [1:0] KIND_ACK = 2'h0;
  localparam logic [1:0] KIND_RESP = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_HEAD = 3'b001, T_LEN = 3'b011, T_TYPE = 3'b010,
    T_PNUM = 3'b110, T_BODY = 3'b111, T_CSUM = 3'b101, T_FOOT = 3'b100
  } ihf_tx_e;
endpackage

/* src/ihf_framer.sv */
// host packet framer: frame check, command dispatch, reply and data packets
// Function
// - one reply packet per accepted host command
// - no reply for utc, start, stop
// - commands start 24 24, replies 23 23
// - length byte counts the whole packet
// - responses carry two-byte packet number after type
// - packet number increments and wraps at 65535
// - length eight means no payload bytes
// - checksum sums type and payload bytes
// - every packet ends with 0d 0a
// - ack: header, 0a, type, code, reserved, sum
// - codes 0 to 4 success and basic errors
// - codes 6,7,10,11,12 defined, others reserved
// - data packet: 2e-style length, ab, status, counter
// - accel status 000 good, 111 unreliable
// - gyro status 00000 good, 11111 unreliable
// - sample counter increments and wraps at 255
// - field select chooses which data fields appear
// - timestamp is eight bytes of microseconds
// - format setting sets numeric representation
// - reset into command mode, start/stop switch
// - streaming acts only on stop and utc
module ihf_framer
  import ihf_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic streaming,
  output logic [7:0] output_format_select,
  output logic [7:0] out_field_select
);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic stream;
    logic pending;
    logic overrun;
    logic [19:0][7:0] rxb;
    logic [4:0] rxn;
    logic chk;
    logic [19:0][7:0] cmd;
    logic [15:0][7:0] resp;
    logic [12:0][31:0] dat;
    logic [7:0] sstat;
    logic [7:0] fsel;
    logic [7:0] ofmt;
    logic [15:0] pktno;
    logic [7:0] sample;
    logic [63:0] ts;
    logic [63:0] tss;
    logic [3:0] pres;
    logic reply_req;
    logic stream_req;
    logic rkind;
    logic [7:0] rcode;
    logic [4:0] rlen;
    ihf_tx_e ph;
    logic cnt;
    logic [5:0] k;
    logic [1:0] kind;
    logic [15:0] csum;
    logic [7:0] ttype;
    logic txv;
    logic [7:0] txd;
  } ihf_state_s;

  ihf_state_s s;
  ihf_state_s next_s;
  logic frame_good;
  logic [7:0] frame_type;

  // header, length range, footer and checksum of a received frame
  function automatic logic frame_ok(input logic [19:0][7:0] b);
    logic [15:0] sum;
    logic [4:0] l;
    logic ok;
    sum = 16'h0000;
    l = b[2][4:0];
    ok = (b[0] == HDR_CMD) && (b[1] == HDR_CMD) &&
         (b[2] >= LEN_MIN) && (b[2] <= FRAME_BYTES);
    for (int i = 3; i < 20; i++) begin
      if (i <= int'(l) - 5) begin
        sum = sum + {8'h00, b[i]};
      end
    end
    if (ok) begin
      ok = (b[l - 5'd2] == FTR_CR) && (b[l - 5'd1] == FTR_LF) &&
           (sum == {b[l - 5'd4], b[l - 5'd3]});
    end
    return ok;
  endfunction

  // only the documented result codes may leave the block
  function automatic logic code_legal(input logic [7:0] c);
    case (c)
      RC_OK, RC_NAK, RC_WR_ERR, RC_RD_ERR, RC_BAD_ARG: return 1'b1;
      RC_FL_WR, RC_FL_RD, RC_REG_WR, RC_REG_RD, RC_WEAR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // data group of a four-byte field: accel, gyro, temp, dvel, dangle
  function automatic logic [2:0] field_group(input logic [3:0] f);
    if (f < 4'd3) return 3'd0;
    if (f < 4'd6) return 3'd1;
    if (f == 4'd6) return 3'd2;
    if (f < 4'd10) return 3'd3;
    return 3'd4;
  endfunction

  // packet length for the selected data fields
  function automatic logic [7:0] data_len(input logic [7:0] sel);
    logic [7:0] n;
    n = LEN_DATA_BASE;
    for (int f = 0; f < 13; f++) begin
      if (sel[field_group(4'(f))]) begin
        n = n + 8'd4;
      end
    end
    return n;
  endfunction

  // byte-lane merge for writable registers
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign frame_good = frame_ok(s.rxb);
  assign frame_type = s.rxb[3];

  // whole next-state computation
  always_comb begin
    logic [5:0] ai;
    logic [5:0] w;
    logic wr;
    logic [7:0] b;
    logic skip;
    logic step;
    logic [5:0] d;
    logic [31:0] rw;
    ai = avs_address[7:2];
    w = 6'h00;
    wr = avs_write && !s.waitreq;
    b = 8'h00;
    skip = 1'b0;
    step = !s.txv || tx_ready;
    d = 6'h00;
    rw = 32'h0000_0000;
    next_s = s;

    // bus: one wait cycle, then the answer; write lands on that edge
    next_s.waitreq = !((avs_read || avs_write) && s.waitreq);
    if (avs_read && s.waitreq) begin
      rw = 32'h0000_0000;
      if (ai == OFF_CTRL[7:2]) begin
        rw = {16'h0000, s.ofmt, s.fsel};
      end else if (ai == OFF_STATUS[7:2]) begin
        rw = {s.pktno, s.sample, 4'h0, s.overrun,
              (s.ph != T_IDLE) || s.txv, s.pending, s.stream};
      end else if (ai >= OFF_CMD[7:2] && ai < OFF_CMD[7:2] + CMD_WORDS) begin
        w = ai - OFF_CMD[7:2];
        rw = {s.cmd[4*w+3], s.cmd[4*w+2], s.cmd[4*w+1], s.cmd[4*w]};
      end else if (ai >= OFF_RESP[7:2] &&
                   ai < OFF_RESP[7:2] + RESP_WORDS) begin
        w = ai - OFF_RESP[7:2];
        rw = {s.resp[4*w+3], s.resp[4*w+2], s.resp[4*w+1], s.resp[4*w]};
      end else if (ai == OFF_SSTAT[7:2]) begin
        rw = {24'h000000, s.sstat};
      end else if (ai == OFF_TS_LO[7:2]) begin
        rw = s.ts[31:0];
      end else if (ai == OFF_TS_HI[7:2]) begin
        rw = s.ts[63:32];
      end else if (ai >= OFF_DATA[7:2] &&
                   ai < OFF_DATA[7:2] + DATA_WORDS) begin
        rw = s.dat[ai - OFF_DATA[7:2]];
      end
      next_s.rdata = rw;
    end

    // register writes
    if (wr) begin
      if (ai == OFF_CTRL[7:2]) begin
        rw = be_merge({16'h0000, s.ofmt, s.fsel}, avs_writedata,
                      avs_byteenable);
        next_s.fsel = rw[7:0];
        next_s.ofmt = rw[15:8];
      end else if (ai == OFF_STATUS[7:2]) begin
        if (avs_byteenable[0] && avs_writedata[3]) begin
          next_s.overrun = 1'b0;
        end
      end else if (ai == OFF_REPLY[7:2]) begin
        // a reply is taken once per pending command, legal code only
        if (s.pending && !s.reply_req && code_legal(avs_writedata[7:0]) &&
            avs_writedata[REPLY_LEN_LSB +: 5] <= RESP_MAX) begin
          next_s.pending = 1'b0;
          next_s.reply_req = 1'b1;
          next_s.rkind = avs_writedata[REPLY_KIND_BIT];
          next_s.rcode = avs_writedata[7:0];
          next_s.rlen = avs_writedata[REPLY_LEN_LSB +: 5];
        end
      end else if (ai >= OFF_RESP[7:2] &&
                   ai < OFF_RESP[7:2] + RESP_WORDS) begin
        w = ai - OFF_RESP[7:2];
        rw = be_merge({s.resp[4*w+3], s.resp[4*w+2], s.resp[4*w+1],
                       s.resp[4*w]}, avs_writedata, avs_byteenable);
        {next_s.resp[4*w+3], next_s.resp[4*w+2], next_s.resp[4*w+1],
         next_s.resp[4*w]} = rw;
      end else if (ai == OFF_SSTAT[7:2]) begin
        if (avs_byteenable[0]) begin
          next_s.sstat = avs_writedata[7:0];
        end
      end else if (ai == OFF_GO[7:2]) begin
        if (s.stream) begin
          next_s.stream_req = 1'b1;
        end
      end else if (ai >= OFF_DATA[7:2] &&
                   ai < OFF_DATA[7:2] + DATA_WORDS) begin
        next_s.dat[ai - OFF_DATA[7:2]] =
          be_merge(s.dat[ai - OFF_DATA[7:2]], avs_writedata, avs_byteenable);
      end
    end

    // microsecond timestamp
    if (s.pres == US_TICKS - 4'd1) begin
      next_s.pres = 4'h0;
      next_s.ts = s.ts + 64'd1;
    end else begin
      next_s.pres = s.pres + 4'd1;
    end

    // receive: every host frame is twenty bytes, counted blindly
    next_s.chk = 1'b0;
    if (rx_valid) begin
      next_s.rxb[s.rxn] = rx_data;
      if (s.rxn == FRAME_LAST) begin
        next_s.rxn = 5'h00;
        next_s.chk = 1'b1;
      end else begin
        next_s.rxn = s.rxn + 5'd1;
      end
    end

    // dispatch a checked frame; a bad one is dropped without a word
    if (s.chk && frame_good) begin
      if (frame_type == TYPE_UTC) begin
        next_s.ts = {s.rxb[4], s.rxb[5], s.rxb[6], s.rxb[7],
                     s.rxb[8], s.rxb[9], s.rxb[10], s.rxb[11]};
        next_s.pres = 4'h0;
      end else if (frame_type == TYPE_STOP) begin
        next_s.stream = 1'b0;
        next_s.stream_req = 1'b0;
      end else if (s.stream) begin
        next_s.stream = 1'b1;
      end else if (frame_type == TYPE_START) begin
        next_s.stream = 1'b1;
      end else if (next_s.pending || next_s.reply_req) begin
        next_s.overrun = 1'b1; // previous command still unanswered
      end else begin
        next_s.cmd = s.rxb; // a reply clear in this cycle flags overrun instead
        next_s.pending = 1'b1;
      end
    end

    // transmit sequencer; at most one byte per step, held until tx_ready
    if (step) begin
      next_s.txv = 1'b0;
      case (s.ph)
        T_IDLE: begin
          next_s.cnt = 1'b0;
          if (s.reply_req) begin
            next_s.reply_req = 1'b0;
            next_s.kind = s.rkind ? KIND_RESP : KIND_ACK;
            next_s.ttype = s.cmd[3];
            next_s.ph = T_HEAD;
          end else if (s.stream_req) begin
            // a go write landing now queues the next packet: set wins
            next_s.stream_req = wr && (ai == OFF_GO[7:2]) && s.stream;
            next_s.tss = s.ts; // frozen so a carry cannot tear it
            next_s.kind = KIND_DATA;
            next_s.ttype = TYPE_DATA;
            next_s.ph = T_HEAD;
          end
        end
        T_HEAD: begin
          next_s.txv = 1'b1;
          next_s.txd = HDR_RSP;
          next_s.cnt = !s.cnt;
          if (s.cnt) begin
            next_s.ph = T_LEN;
          end
        end
        T_LEN: begin
          next_s.txv = 1'b1;
          if (s.kind == KIND_ACK) begin
            next_s.txd = LEN_ACK;
          end else if (s.kind == KIND_RESP) begin
            next_s.txd = LEN_RSP_BASE + {3'b000, s.rlen};
          end else begin
            next_s.txd = data_len(s.fsel);
          end
          next_s.ph = T_TYPE;
        end
        T_TYPE: begin
          next_s.txv = 1'b1;
          next_s.txd = s.ttype;
          next_s.csum = {8'h00, s.ttype};
          next_s.k = 6'h00;
          next_s.cnt = 1'b0;
          next_s.ph = (s.kind == KIND_RESP) ? T_PNUM : T_BODY;
        end
        T_PNUM: begin
          b = s.cnt ? s.pktno[7:0] : s.pktno[15:8];
          next_s.txv = 1'b1;
          next_s.txd = b;
          next_s.csum = s.csum + {8'h00, b};
          next_s.cnt = !s.cnt;
          if (s.cnt) begin
            next_s.ph = T_BODY;
          end
        end
        T_BODY: begin
          if ((s.kind == KIND_ACK && s.k == 6'd2) ||
              (s.kind == KIND_RESP && s.k == {1'b0, s.rlen}) ||
              (s.kind == KIND_DATA && s.k == DATA_BODY_END)) begin
            next_s.cnt = 1'b0;
            next_s.ph = T_CSUM;
          end else begin
            if (s.kind == KIND_ACK) begin
              b = (s.k == 6'd0) ? s.rcode : 8'h00; // reserved byte
            end else if (s.kind == KIND_RESP) begin
              b = s.resp[s.k[3:0]];
            end else if (s.k == 6'd0) begin
              b = s.sstat;
            end else if (s.k == 6'd1) begin
              b = s.sample;
            end else if (s.k < DATA_FIRST) begin
              b = s.tss[8*(6'd9 - s.k) +: 8];
            end else begin
              d = s.k - DATA_FIRST;
              b = s.dat[d[5:2]][8*(2'd3 - d[1:0]) +: 8];
              skip = !s.fsel[field_group(d[5:2])];
            end
            next_s.k = s.k + 6'd1;
            if (!skip) begin
              next_s.txv = 1'b1;
              next_s.txd = b;
              next_s.csum = s.csum + {8'h00, b};
            end
          end
        end
        T_CSUM: begin
          next_s.txv = 1'b1;
          next_s.txd = s.cnt ? s.csum[7:0] : s.csum[15:8];
          next_s.cnt = !s.cnt;
          if (s.cnt) begin
            next_s.ph = T_FOOT;
          end
        end
        T_FOOT: begin
          next_s.txv = 1'b1;
          next_s.txd = s.cnt ? FTR_LF : FTR_CR;
          next_s.cnt = !s.cnt;
          if (s.cnt) begin
            next_s.ph = T_IDLE;
            if (s.kind == KIND_RESP) begin
              next_s.pktno = s.pktno + 16'd1;
            end
            if (s.kind == KIND_DATA) begin
              next_s.sample = s.sample + 8'd1;
            end
          end
        end
        default: begin
          next_s.ph = T_IDLE;
        end
      endcase
    end
  end

  // state register; reset lands in command mode with nothing pending
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.fsel <= FSEL_RST;
      s.ofmt <= OFMT_RST;
      s.sstat <= SSTAT_RST;
      s.ph <= T_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign tx_valid = s.txv;
  assign tx_data = s.txd;
  assign streaming = s.stream;
  assign output_format_select = s.ofmt;
  assign out_field_select = s.fsel;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_hdr_byte: assert property ((s.ph == T_LEN && s.txv) |->
    s.txd == HDR_RSP) else $error("second header byte wrong");
  a_ack_len: assert property
    ((s.ph == T_TYPE && s.txv && s.kind == KIND_ACK) |-> s.txd == LEN_ACK)
    else $error("ack length byte wrong");
  a_foot_end: assert property
    (($past(s.ph) == T_FOOT && s.ph == T_IDLE) |-> s.txv && s.txd == FTR_LF)
    else $error("packet not ended by line feed");
  a_csum_low: assert property
    ((s.ph == T_FOOT && !s.cnt && s.txv) |-> s.txd == s.csum[7:0])
    else $error("checksum low byte not last");
  a_pktno_step: assert property
    (($past(s.ph) == T_FOOT && s.ph == T_IDLE && s.kind == KIND_RESP) |->
     s.pktno == $past(s.pktno) + 16'd1) else $error("packet number stuck");
  a_sample_step: assert property
    (($past(s.ph) == T_FOOT && s.ph == T_IDLE && s.kind == KIND_DATA) |->
     s.sample == $past(s.sample) + 8'd1) else $error("sample counter stuck");
  a_data_type: assert property
    ((s.ph == T_BODY && s.kind == KIND_DATA && s.k == 6'd0 && s.txv) |->
     s.txd == TYPE_DATA) else $error("data packet type wrong");
  a_quiet_cmds: assert property
    ((s.chk && frame_good && (frame_type == TYPE_START ||
      frame_type == TYPE_STOP || frame_type == TYPE_UTC)) |=>
     !$rose(s.pending)) else $error("reply raised for silent command");
  a_stream_gate: assert property
    ((s.chk && frame_good && s.stream && frame_type != TYPE_STOP) |=>
     s.stream && !$rose(s.pending)) else $error("command served in stream");
  a_start_mode: assert property
    ((s.chk && frame_good && !s.stream && frame_type == TYPE_START) |=>
     s.stream && !$rose(s.pending)) else $error("start not taken");
  a_bad_drop: assert property
    ((s.chk && !frame_good) |=> $stable(s.stream) && !$rose(s.pending))
    else $error("bad frame acted on");
endmodule

/* verif/ihf_host_model.sv */
// host side model: sends padded command frames, collects device bytes
module ihf_host_model (
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] seen[$];
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // a slow host accepts every other cycle so bytes must stand
  assign tx_ready = !slow || ph[0];
  // capture each byte the transport takes
  always @(posedge clock) begin
    ph <= ph + 2'h1;
    if (tx_valid && tx_ready) seen.push_back(tx_data);
  end
  // one frame, corrupt sum on request, one byte per cycle
  task automatic send(input logic [7:0] typ, input logic [7:0] pl[$],
                      input bit bad);
    logic [7:0] f[$];
    logic [15:0] s;
    s = {8'h00, typ};
    foreach (pl[i]) s += {8'h00, pl[i]};
    if (bad) s ^= 16'h0001;
    f = {8'h24, 8'h24, 8'(8 + pl.size()), typ};
    f = {f, pl, s[15:8], s[7:0], 8'h0d, 8'h0a};
    while (f.size() < 20) f.push_back(8'h00);
    foreach (f[i]) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~f[19]; // released line shows no stale value
  endtask
endmodule

/* verif/ihf_framer_test.sv */
// self-checking bench: acks, responses, drops, streaming data
module ihf_framer_test
  import ihf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, rx_valid, tx_valid, tx_ready, streaming;
  logic [7:0] rx_data, tx_data, output_format_select, out_field_select;
  logic [31:0] rd;
  int miscompares = 0;
  int cmp_count = 0;
  ihf_framer dut_u (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .streaming(streaming),
    .output_format_select(output_format_select),
    .out_field_select(out_field_select));
  ihf_host_model host_u (.clock(clock), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  // 10 MHz clock
  initial forever #50 clock = ~clock;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one bus cycle; an idle edge after release avoids double drives
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wpend(input logic e);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rd[1] !== e && n < 40);
    chk("pending", {31'h0, e}, {31'h0, rd[1]});
  endtask
  // waits for a whole packet, then compares it byte by byte
  task automatic cmp(input logic [7:0] e[$]);
    int n;
    n = 0;
    while (host_u.seen.size() < e.size() && n < 3000) begin
      @(posedge clock);
      n++;
    end
    repeat (5) @(posedge clock);
    chk("tx_count", 32'(e.size()), 32'(host_u.seen.size()));
    foreach (e[i]) chk("tx_byte", {24'h0, e[i]}, {24'h0, host_u.seen[i]});
    host_u.seen.delete();
  endtask
  // data packet; timestamp only has a window since it keeps ticking
  task automatic dpk(input int nw, input logic [7:0] smp,
                     input logic [7:0] ln);
    logic [7:0] e[$];
    logic [63:0] ts;
    logic [15:0] s;
    logic [31:0] w;
    repeat (400) @(posedge clock);
    for (int i = 0; i < 8; i++) ts = {ts[55:0], host_u.seen[6+i]};
    chk("timestamp", 32'h1, {31'h0, ts >= 64'h1000 && ts < 64'h2000});
    e = {HDR_RSP, HDR_RSP, ln, TYPE_DATA, 8'he1, smp};
    for (int i = 7; i >= 0; i--) e.push_back(ts[8*i+:8]);
    for (int k = 0; k < nw; k++) begin
      w = 32'h10203040 + 32'(k);
      e = {e, w[31:24], w[23:16], w[15:8], w[7:0]};
    end
    s = 16'h0;
    for (int i = 3; i < e.size(); i++) s += {8'h00, e[i]};
    cmp({e, s[15:8], s[7:0], FTR_CR, FTR_LF});
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #4000000;
    miscompares++;
    end_sim();
  end
  initial begin
    logic [7:0] codes[10];
    logic [7:0] rsv[5];
    logic [7:0] t;
    codes = '{RC_OK, RC_NAK, RC_WR_ERR, RC_RD_ERR, RC_BAD_ARG, RC_FL_WR,
              RC_FL_RD, RC_REG_WR, RC_REG_RD, RC_WEAR};
    rsv = '{8'h05, 8'h08, 8'h09, 8'h0d, 8'hff};
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("streaming", 32'h0, {31'h0, streaming});
    chk("fsel", 32'h1f, {24'h0, out_field_select});
    chk("ofmt", 32'h0, {24'h0, output_format_select});
    bus(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", 32'h1f, rd);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // every defined code acked, slow host on odd passes
    foreach (codes[i]) begin
      t = 8'h30 + 8'(i);
      host_u.slow <= i[0];
      host_u.send(t, '{}, 1'b0);
      wpend(1'b1);
      if (i == 0) begin
        bus(1'b0, OFF_CMD, 32'h0);
        chk("cmd_word", {t, LEN_MIN, HDR_CMD, HDR_CMD}, rd);
        foreach (rsv[j]) bus(1'b1, OFF_REPLY, {24'h0, rsv[j]});
        wpend(1'b1);
        chk("no_reply", 32'h0, 32'(host_u.seen.size()));
        // a second command while one is pending is dropped and flagged
        host_u.send(t, '{}, 1'b0);
        repeat (4) @(posedge clock);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk("overrun", 32'h1, {31'h0, rd[3]});
        bus(1'b1, OFF_STATUS, 32'h8);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk("overrun_clr", 32'h0, {31'h0, rd[3]});
      end
      bus(1'b1, OFF_REPLY, {24'h0, codes[i]});
      cmp('{HDR_RSP, HDR_RSP, LEN_ACK, t, codes[i], 8'h00, 8'h00,
            t + codes[i], FTR_CR, FTR_LF});
    end
    $display("test ack done");
    // two responses, packet number counts up
    bus(1'b1, OFF_RESP, 32'h44332211);
    for (int k = 0; k < 2; k++) begin
      host_u.send(8'h26, '{}, 1'b0);
      wpend(1'b1);
      bus(1'b1, OFF_REPLY, 32'h00020100);
      cmp('{HDR_RSP, HDR_RSP, 8'h0c, 8'h26, 8'h00, 8'(k), 8'h11, 8'h22,
            8'h00, 8'(8'h59 + k), FTR_CR, FTR_LF});
    end
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("pkt_number", 32'h2, {16'h0, rd[31:16]});
    host_u.send(8'h26, '{}, 1'b1);
    repeat (30) @(posedge clock);
    wpend(1'b0);
    chk("bad_sum", 32'h0, 32'(host_u.seen.size()));
    $display("test response done");
    // streaming: no reply to start, utc, stop; others ignored
    host_u.send(TYPE_START, '{}, 1'b0);
    repeat (10) @(posedge clock);
    chk("streaming", 32'h1, {31'h0, streaming});
    host_u.send(TYPE_UTC, '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h10,
                            8'h00}, 1'b0);
    host_u.send(8'h31, '{}, 1'b0);
    repeat (30) @(posedge clock);
    wpend(1'b0);
    bus(1'b0, OFF_TS_LO, 32'h0);
    chk("ts_lo", 32'h1, {31'h0, rd >= 32'h1000 && rd < 32'h1100});
    chk("no_reply", 32'h0, 32'(host_u.seen.size()));
    bus(1'b1, OFF_CTRL, 32'h00000301);
    chk("ofmt", 32'h3, {24'h0, output_format_select});
    chk("fsel", 32'h1, {24'h0, out_field_select});
    bus(1'b1, OFF_SSTAT, 32'h000000e1);
    for (int k = 0; k < 13; k++)
      bus(1'b1, OFF_DATA + 8'(4 * k), 32'h10203040 + 32'(k));
    bus(1'b1, OFF_GO, 32'h0);
    dpk(3, 8'h00, 8'h1e);
    bus(1'b1, OFF_CTRL, 32'h0000001f);
    bus(1'b1, OFF_GO, 32'h0);
    dpk(13, 8'h01, 8'h46);
    host_u.send(TYPE_STOP, '{}, 1'b0);
    repeat (10) @(posedge clock);
    chk("streaming", 32'h0, {31'h0, streaming});
    chk("no_reply", 32'h0, 32'(host_u.seen.size()));
    $display("test streaming done");
    end_sim();
  end
endmodule
